//--- hw/wake_regs.svh
// register offsets, field positions, reset values and timing for the wake/power-loss register group
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH
`define OFF_KEY_INDEX 8'he1
`define OFF_KEY_DATA 8'he2
`define OFF_EVT_STATUS 8'he3
`define OFF_PL_CTRL 8'he4
`define OFF_RST_SRC 8'he5
`define OFF_LAST_STATE 8'he6
`define RST_KEY_INDEX 8'h00
`define RST_KEY_DATA 8'hff
`define RST_EVT_STATUS 8'h08
`define RST_PL_CTRL 8'h00
`define RST_RST_SRC 8'h00
`define RST_LAST_STATE 8'h00
`define WMASK_PL_CTRL 8'hfc
`define WMASK_RST_SRC 8'h1d
`define WMASK_LAST_STATE 8'h10
`define SET1_HI 4'h0
`define RX_HI 4'h1
`define SET2_HI 4'h3
`define SET3_HI 4'h4
`define SET_LEN 15
`define KEY_SLOTS 45
`define SET2_SLOT 6'h0f
`define SET3_SLOT 6'h1e
`define EVT_STBY 5
`define EVT_LOSS_OFF 4
`define EVT_THERM 3
`define EVT_PANEL 2
`define EVT_MOUSE 1
`define EVT_KBD 0
`define PL_LONG_PULSE 7
`define PL_POLICY_HI 6
`define PL_POLICY_LO 5
`define PL_GATE_EN 4
`define PL_ANY_KEY 3
`define PL_HUNT 2
`define RS_VID 4
`define RS_GPB 3
`define RS_GPA 2
`define RS_PG_DIS 0
`define LS_OFF 4
`define POLICY_OFF 2'b00
`define POLICY_ON 2'b01
`define POLICY_RESTORE 2'b10
`define POLICY_USER 2'b11
`define PULSE_TIME_MS 4000
`define CLK_MHZ 250
`endif

//--- hw/wake_pkg.sv
// types shared by the wake/power-loss register group
package wake_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic {ST_IDLE, ST_PULSE} pulse_state_t;
endpackage

//--- hw/wake_power_loss_control_regs.sv
// wake-key window, event status and power-loss recovery registers
// What this block does
// R1: index selects key set slots in data window
// R2: received key codes readable at 0x10-0x1e
// R3: data register accesses indexed location, resets ffh
// R4: status bit5 flags standby toggle, read-clears
// R5: bit4 shows off decision only with long pulse
// R6: bit3 thermal shutdown flag, status resets 08h
// R7: bit2 panel switch event, cleared by read
// R8: bit1 latches mouse wake until read
// R9: bit0 latches keyboard wake, cleared by read
// R10: long pulse drives power switch low 4s
// R11: two-bit policy chooses recovery after power returns
// R12: control bit4 enables standby gate output
// R13: bit3 selects programmed keys or any key
// R14: hunting mode bit self-clears on wake event
// R15: reset-source bit4 selects voltage-id reset source
// R16: reset-source bit3 selects gpio b reset source
// R17: reset-source bit2 selects gpio a reset source
// R18: reset-source bit0 gates atx power-good control
// R19: last-state flag: 0 on, 1 off, battery kept
// R20: reserved bits read zero, ignore writes
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "wake_regs.svh"
module wake_power_loss_control_regs #(
  parameter int unsigned PULSE_CYCLES = 32'(`PULSE_TIME_MS * 1000 * `CLK_MHZ)
) (
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic standby_reset,
  input wire logic battery_reset,
  // register port
  input wire logic [7:0] addr,
  input wire wake_pkg::byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // keyboard receive path, same clock
  input wire logic key_valid,
  input wire wake_pkg::byte_t key_code,
  // asynchronous event pins
  input wire logic keyboard_wake_in,
  input wire logic mouse_wake_in,
  input wire logic panel_switch_in,
  input wire logic thermal_shutdown_in,
  input wire logic standby_supply,
  input wire logic system_was_on_in,
  input wire logic atx_power_good_in,
  input wire logic core_power_ok_in,
  // power and reset-steering outputs
  output logic power_switch_out_n,
  output logic standby_gate_n,
  output logic system_power_on,
  output logic power_good_out,
  output logic second_power_good_out,
  output logic any_key_wake,
  output logic hunting_enable,
  output logic voltage_id_reset_select,
  output logic gpio_pin_b_reset_select,
  output logic gpio_pin_a_reset_select
);
  import wake_pkg::*;

  localparam int SYNC_W = 8;

  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
  logic [SYNC_W-1:0] rise, fall;
  logic kb_rise, ms_rise, panel_rise, therm_rise, stby_toggle, stby_rise;
  logic was_on_s, atx_s, core_ok_s;
  byte_t index_q, pl_q, rs_q, ls_q, rdata_q, rdata_d;
  byte_t mem_q [0:`KEY_SLOTS-1];
  byte_t rx_q [0:`SET_LEN-1];
  logic [5:0] evt_q, evt_set;
  logic [6:0] slot_info;
  logic slot_ok, rx_ok;
  logic wr_index, wr_data, wr_pl, wr_rs, wr_ls, rd_status;
  logic kbd_evt, ms_evt, decide_on, loss_off_bit;
  logic [1:0] policy;
  pulse_state_t state_q;
  logic [31:0] pulse_cnt_q;
  logic power_switch_out_n_n_q, gate_n_q, sys_on_q, pg_q, pg2_q;

  // two flops on every pin before use; third stage only feeds edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {core_power_ok_in, atx_power_good_in, system_was_on_in, standby_supply,
                  thermal_shutdown_in, panel_switch_in, mouse_wake_in, keyboard_wake_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~sync3_q;
  assign fall = ~sync2_q & sync3_q;
  assign kb_rise = rise[0];
  assign ms_rise = rise[1];
  assign panel_rise = rise[2];
  assign therm_rise = rise[3];
  assign stby_toggle = rise[4] | fall[4];
  assign stby_rise = rise[4];
  assign was_on_s = sync2_q[5];
  assign atx_s = sync2_q[6];
  assign core_ok_s = sync2_q[7];

  // register port decode
  assign wr_index = wr && (addr == `OFF_KEY_INDEX);
  assign wr_data = wr && (addr == `OFF_KEY_DATA);
  assign wr_pl = wr && (addr == `OFF_PL_CTRL);
  assign wr_rs = wr && (addr == `OFF_RST_SRC);
  assign wr_ls = wr && (addr == `OFF_LAST_STATE);
  assign rd_status = rd && (addr == `OFF_EVT_STATUS);

  // index to key-set slot; three sets of 15 bytes, holes at index x_f
  function automatic logic [6:0] key_slot(input byte_t idx);
    logic [6:0] r;
    r = 7'h00;
    if (idx[3:0] != 4'hf) begin
      case (idx[7:4])
        `SET1_HI: r = {1'b1, 2'b00, idx[3:0]};
        `SET2_HI: r = {1'b1, `SET2_SLOT + {2'b00, idx[3:0]}};
        `SET3_HI: r = {1'b1, `SET3_SLOT + {2'b00, idx[3:0]}};
        default: r = 7'h00;
      endcase
    end
    return r;
  endfunction

  assign slot_info = key_slot(index_q); // R1
  assign slot_ok = slot_info[6];
  assign rx_ok = (index_q[7:4] == `RX_HI) && (index_q[3:0] != 4'hf); // R2

  // index register, standby kept
  always_ff @(posedge clk) begin
    if (standby_reset) begin
      index_q <= `RST_KEY_INDEX;
    end else if (wr_index) begin
      index_q <= wdata; // R1
    end
  end

  // stored wake keys; unmapped indices swallow writes
  always_ff @(posedge clk) begin
    if (standby_reset) begin
      for (int i = 0; i < `KEY_SLOTS; i++) begin
        mem_q[i] <= `RST_KEY_DATA; // R3
      end
    end else if (wr_data && slot_ok) begin
      mem_q[slot_info[5:0]] <= wdata; // R3
    end
  end

  // received key history, newest at the top slot, older ones shift down
  genvar g;
  generate
    for (g = 0; g < `SET_LEN; g++) begin : g_rx
      always_ff @(posedge clk) begin
        if (standby_reset) begin
          rx_q[g] <= `RST_KEY_DATA;
        end else if (key_valid) begin
          if (g == `SET_LEN - 1) begin
            rx_q[g] <= key_code; // R2
          end else begin
            rx_q[g] <= rx_q[(g + 1) % `SET_LEN]; // R2
          end
        end
      end
    end
  endgenerate

  // control registers; battery bits survive standby and bus resets
  always_ff @(posedge clk) begin
    if (battery_reset) begin
      pl_q[7:5] <= 3'(`RST_PL_CTRL >> 5);
    end else if (wr_pl) begin
      pl_q[7:5] <= wdata[7:5]; // R10 R11
    end
  end

  always_ff @(posedge clk) begin
    if (standby_reset) begin
      pl_q[4] <= 1'(`RST_PL_CTRL >> 4);
    end else if (wr_pl) begin
      pl_q[4] <= wdata[`PL_GATE_EN]; // R12
    end
  end

  // hunting self-clear loses to a software write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pl_q[3:0] <= 4'(`RST_PL_CTRL);
    end else if (wr_pl) begin
      pl_q[3:0] <= {wdata[3:2], 2'b00}; // R13 R20
    end else if (kbd_evt || ms_evt) begin
      pl_q[`PL_HUNT] <= 1'b0; // R14
    end
  end

  always_ff @(posedge clk) begin
    if (standby_reset) begin
      rs_q <= `RST_RST_SRC;
    end else if (wr_rs) begin
      rs_q <= wdata & `WMASK_RST_SRC; // R15 R16 R17 R18 R20
    end
  end

  always_ff @(posedge clk) begin
    if (battery_reset) begin
      ls_q <= `RST_LAST_STATE;
    end else if (wr_ls) begin
      ls_q <= wdata & `WMASK_LAST_STATE; // R19
    end
  end

  // any-key mode turns each received byte into a keyboard wake
  assign kbd_evt = kb_rise || (pl_q[`PL_ANY_KEY] && key_valid); // R13
  assign ms_evt = ms_rise;

  // event flags: a new event in a reading cycle stays set for the next read
  assign evt_set = {stby_toggle, 1'b0, therm_rise, panel_rise, ms_evt, kbd_evt};
  always_ff @(posedge clk) begin
    if (standby_reset) begin
      evt_q <= 6'(`RST_EVT_STATUS); // R6
    end else begin
      evt_q <= (evt_q & {6{~rd_status}}) | evt_set; // R4 R6 R7 R8 R9
    end
  end

  // recovery policy decision
  assign policy = pl_q[`PL_POLICY_HI:`PL_POLICY_LO];
  always_comb begin
    case (policy)
      `POLICY_OFF: decide_on = 1'b0; // R11
      `POLICY_ON: decide_on = 1'b1; // R11
      `POLICY_RESTORE: decide_on = was_on_s; // R11
      default: decide_on = ~ls_q[`LS_OFF]; // R11 R19
    endcase
  end
  assign loss_off_bit = pl_q[`PL_LONG_PULSE] & ~decide_on; // R5

  // power returns on standby rise; latch the system state chosen then
  always_ff @(posedge clk) begin
    if (battery_reset) begin
      sys_on_q <= 1'b0;
    end else if (stby_rise) begin
      sys_on_q <= decide_on; // R11
    end
  end

  // long power-switch pulse when recovery says off
  always_ff @(posedge clk) begin
    if (standby_reset) begin
      state_q <= ST_IDLE;
      pulse_cnt_q <= '0;
      power_switch_out_n_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (stby_rise && pl_q[`PL_LONG_PULSE] && !decide_on) begin
            state_q <= ST_PULSE; // R10
            pulse_cnt_q <= PULSE_CYCLES - 32'd1;
            power_switch_out_n_n_q <= 1'b0; // R10
          end
        end
        ST_PULSE: begin
          if (pulse_cnt_q == '0) begin
            state_q <= ST_IDLE;
            power_switch_out_n_n_q <= 1'b1; // R10
          end else begin
            pulse_cnt_q <= pulse_cnt_q - 32'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          power_switch_out_n_n_q <= 1'b1;
        end
      endcase
    end
  end

  // gate and power-good outputs; disabling atx control lets core ok alone drive both power-good outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_n_q <= 1'b1;
      pg_q <= 1'b0;
      pg2_q <= 1'b0;
    end else begin
      gate_n_q <= ~(pl_q[`PL_GATE_EN] & sys_on_q); // R12
      pg_q <= core_ok_s & (atx_s | rs_q[`RS_PG_DIS]); // R18
      pg2_q <= core_ok_s & (atx_s | rs_q[`RS_PG_DIS]); // R18
    end
  end

  // read mux; unmapped addresses read 00, key holes read ff like erased storage
  always_comb begin
    rdata_d = 8'h00;
    case (addr)
      `OFF_KEY_INDEX: rdata_d = index_q;
      `OFF_KEY_DATA: begin
        if (slot_ok) begin
          rdata_d = mem_q[slot_info[5:0]]; // R3
        end else if (rx_ok) begin
          rdata_d = rx_q[index_q[3:0]]; // R2
        end else begin
          rdata_d = 8'hff;
        end
      end
      `OFF_EVT_STATUS: rdata_d = {2'b00, evt_q[`EVT_STBY], loss_off_bit, evt_q[3:0]}; // R4 R5 R20
      `OFF_PL_CTRL: rdata_d = pl_q & `WMASK_PL_CTRL; // R20
      `OFF_RST_SRC: rdata_d = rs_q;
      `OFF_LAST_STATE: rdata_d = ls_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign power_switch_out_n = power_switch_out_n_n_q;
  assign standby_gate_n = gate_n_q;
  assign system_power_on = sys_on_q;
  assign power_good_out = pg_q;
  assign second_power_good_out = pg2_q;
  assign any_key_wake = pl_q[`PL_ANY_KEY];
  assign hunting_enable = pl_q[`PL_HUNT];
  assign voltage_id_reset_select = rs_q[`RS_VID]; // R15
  assign gpio_pin_b_reset_select = rs_q[`RS_GPB]; // R16
  assign gpio_pin_a_reset_select = rs_q[`RS_GPA]; // R17

  // checks
  a_index_store: assert property (@(posedge clk) disable iff (reset || standby_reset) // R1
    wr_index |=> index_q == $past(wdata)) else $error("index not stored");
  a_rx_newest: assert property (@(posedge clk) disable iff (reset || standby_reset) // R2
    key_valid |=> rx_q[`SET_LEN-1] == $past(key_code)) else $error("key code not captured");
  a_data_back: assert property (@(posedge clk) disable iff (reset || standby_reset) // R3
    (wr_data && slot_ok) ##1 !wr ##1 (rd && addr == `OFF_KEY_DATA && $stable(index_q)) |=> rdata == $past(wdata, 3))
    else $error("data window readback wrong");
  a_stby_clear: assert property (@(posedge clk) disable iff (reset || standby_reset) // R4
    rd_status && !stby_toggle |=> !evt_q[`EVT_STBY]) else $error("standby flag not cleared");
  a_loss_zero: assert property (@(posedge clk) disable iff (reset || standby_reset) // R5
    rd_status && !pl_q[`PL_LONG_PULSE] |=> !rdata[`EVT_LOSS_OFF]) else $error("bit4 not zero");
  a_therm_set: assert property (@(posedge clk) disable iff (reset || standby_reset) // R6
    therm_rise |=> evt_q[`EVT_THERM] ##1 (evt_q[`EVT_THERM] || $past(rd_status))) else $error("thermal lost");
  a_panel_set: assert property (@(posedge clk) disable iff (reset || standby_reset) // R7
    panel_rise |=> evt_q[`EVT_PANEL]) else $error("panel event lost");
  a_mouse_hold: assert property (@(posedge clk) disable iff (reset || standby_reset) // R8
    evt_q[`EVT_MOUSE] && !rd_status |=> evt_q[`EVT_MOUSE]) else $error("mouse flag dropped");
  a_kbd_read: assert property (@(posedge clk) disable iff (reset || standby_reset) // R9
    rd_status && evt_q[`EVT_KBD] |=> rdata[`EVT_KBD]) else $error("keyboard flag not reported");
  a_pulse_low: assert property (@(posedge clk) disable iff (reset || standby_reset) // R10
    state_q == ST_PULSE && pulse_cnt_q != '0 |=> !power_switch_out_n_n_q && state_q == ST_PULSE) else $error("pulse ended early");
  a_policy_on: assert property (@(posedge clk) disable iff (reset || battery_reset) // R11
    stby_rise && policy == `POLICY_ON |=> sys_on_q) else $error("policy on ignored");
  a_gate_off: assert property (@(posedge clk) disable iff (reset || standby_reset) // R12
    !pl_q[`PL_GATE_EN] |=> gate_n_q) else $error("gate driven while disabled");
  a_hunt_clear: assert property (@(posedge clk) disable iff (reset) // R14
    hunting_enable && (kbd_evt || ms_evt) && !wr_pl |=> !hunting_enable) else $error("hunting not cleared");
  a_pg_follow: assert property (@(posedge clk) disable iff (reset || standby_reset) // R18
    !rs_q[`RS_PG_DIS] && !atx_s |=> !power_good_out && !second_power_good_out) else $error("atx ignored");
  c_pulse_start: cover property (@(posedge clk) disable iff (reset) $fell(power_switch_out_n_n_q));
  c_status_read: cover property (@(posedge clk) disable iff (reset) rd_status && evt_q[`EVT_KBD]);
  c_hunt_done: cover property (@(posedge clk) disable iff (reset) $fell(hunting_enable));
endmodule
`default_nettype wire

//--- test/power_env.sv
// far-side model: wake event pins and standby supply rail
`timescale 1ns/1ns
`default_nettype none
module power_env #(
  parameter int HOLD = 3
) (
  // control from the bench
  input wire logic clk,
  input wire logic [3:0] fire,
  input wire logic stby_on,
  // pins toward the block
  output logic [3:0] evt_pins,
  output logic standby_supply
);
  int cnt [4];
  // stretch each one-cycle request so the edge survives the synchronisers
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (fire[i]) cnt[i] = HOLD;
      else if (cnt[i] > 0) cnt[i] = cnt[i] - 1;
      evt_pins[i] <= cnt[i] > 0;
    end
  end
  // the rail follows the bench one cycle late, never glitching
  always @(posedge clk) begin
    standby_supply <= stby_on;
  end
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the wake/power-loss register group
`timescale 1ns/1ns
`default_nettype none
`include "wake_regs.svh"
module testbench;
  import wake_pkg::*;
  localparam int PC = 20;
  logic clk, reset, wr, rd, key_valid, stby_on, was_on, atx, core, on, lp;
  logic [7:0] addr, rdata;
  byte_t wdata, key_code, rv, kq [15];
  logic [3:0] fire, evt;
  logic stby, psw_n, gate_n, sys_on, pg1, pg2, anyk, hunt, vsel, bsel, asel;
  int err_count, checks, cyc, lo_cnt, base;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  wake_power_loss_control_regs #(.PULSE_CYCLES(PC)) uut (
    .clk, .reset, .standby_reset(reset), .battery_reset(reset),
    .addr, .wdata, .wr, .rd, .rdata, .key_valid, .key_code,
    .keyboard_wake_in(evt[0]), .mouse_wake_in(evt[1]),
    .panel_switch_in(evt[2]), .thermal_shutdown_in(evt[3]),
    .standby_supply(stby), .system_was_on_in(was_on),
    .atx_power_good_in(atx), .core_power_ok_in(core),
    .power_switch_out_n(psw_n), .standby_gate_n(gate_n), .system_power_on(sys_on),
    .power_good_out(pg1), .second_power_good_out(pg2), .any_key_wake(anyk),
    .hunting_enable(hunt), .voltage_id_reset_select(vsel),
    .gpio_pin_b_reset_select(bsel), .gpio_pin_a_reset_select(asel)
  );
  power_env env (.clk, .fire, .stby_on, .evt_pins(evt), .standby_supply(stby));
  task automatic close_out;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data is valid from the cycle after the strobe until the next read
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // pins pass two sync stages and an edge stage, so allow ten cycles
  task automatic pulse(input int i);
    @(posedge clk);
    fire <= 4'(1 << i);
    @(posedge clk);
    fire <= 4'h0;
    repeat (10) @(posedge clk);
  endtask
  task automatic key(input byte_t k);
    @(posedge clk);
    key_valid <= 1'b1;
    key_code <= k;
  endtask
  // cycle ceiling and power-switch low-time counter
  always @(posedge clk) begin
    cyc++;
    if (psw_n === 1'b0) lo_cnt++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    key_valid = 1'b0;
    key_code = 8'h00;
    fire = 4'h0;
    stby_on = 1'b0;
    was_on = 1'b0;
    atx = 1'b0;
    core = 1'b0;
    void'($urandom(32'h138ede14));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    // reset values, unmapped address, write to read-only status
    rd_chk(`OFF_KEY_INDEX, 8'h00);
    rd_chk(`OFF_KEY_DATA, 8'hff);
    rd_chk(`OFF_EVT_STATUS, 8'h08);
    rd_chk(`OFF_EVT_STATUS, 8'h00);
    rd_chk(`OFF_PL_CTRL, 8'h00);
    rd_chk(`OFF_RST_SRC, 8'h00);
    rd_chk(8'he9, 8'h00);
    wr_reg(`OFF_EVT_STATUS, 8'hff);
    rd_chk(`OFF_EVT_STATUS, 8'h00);
    // keyboard, mouse, panel and thermal flags each latch and clear on read
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd_chk(`OFF_EVT_STATUS, 8'(1 << i));
      rd_chk(`OFF_EVT_STATUS, 8'h00);
    end
    // three stored key sets through the index/data window
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 15; k++) begin
        rv = byte_t'($urandom);
        wr_reg(`OFF_KEY_INDEX, 8'(k) + 8'(s == 0 ? 0 : s * 16 + 32));
        wr_reg(`OFF_KEY_DATA, rv);
        rd_chk(`OFF_KEY_DATA, rv);
      end
    end
    wr_reg(`OFF_KEY_INDEX, 8'h20);
    wr_reg(`OFF_KEY_DATA, 8'h00);
    rd_chk(`OFF_KEY_INDEX, 8'h20);
    rd_chk(`OFF_KEY_DATA, 8'hff);
    // back-to-back received keys, oldest at 0x10
    for (int k = 0; k < 15; k++) begin
      kq[k] = byte_t'($urandom);
      key(kq[k]);
    end
    @(posedge clk);
    key_valid <= 1'b0;
    for (int k = 0; k < 15; k++) begin
      wr_reg(`OFF_KEY_INDEX, 8'h10 + 8'(k));
      rd_chk(`OFF_KEY_DATA, kq[k]);
    end
    // random control and reset-source values, power-good steering
    for (int k = 0; k < 6; k++) begin
      rv = byte_t'($urandom) & 8'h1f;
      wr_reg(`OFF_PL_CTRL, rv);
      rd_chk(`OFF_PL_CTRL, rv & `WMASK_PL_CTRL);
      chk({6'h0, anyk, hunt}, {6'h0, rv[3:2]});
      rv = byte_t'($urandom);
      wr_reg(`OFF_RST_SRC, rv);
      atx <= 1'($urandom);
      core <= 1'($urandom);
      repeat (6) @(posedge clk);
      rd_chk(`OFF_RST_SRC, rv & `WMASK_RST_SRC);
      chk({5'h0, vsel, bsel, asel}, {5'h0, rv[4:2]});
      chk({6'h0, pg1, pg2}, {6'h0, {2{core & (atx | rv[0])}}});
    end
    // hunting drops on a wake event; any-key mode wakes on a plain key
    wr_reg(`OFF_PL_CTRL, 8'h04);
    pulse(1);
    rd_chk(`OFF_PL_CTRL, 8'h00);
    rd_chk(`OFF_EVT_STATUS, 8'h02);
    wr_reg(`OFF_PL_CTRL, 8'h08);
    key(8'h5a);
    @(posedge clk);
    key_valid <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(`OFF_EVT_STATUS, 8'h01);
    // every recovery policy, then policy 00 with the long pulse off
    for (int p = 0; p < 5; p++) begin
      rv = byte_t'($urandom);
      lp = p < 4;
      on = p == 1 ? 1'b1 : p == 2 ? rv[0] : p == 3 ? ~rv[1] : 1'b0;
      wr_reg(`OFF_LAST_STATE, {3'h0, rv[1], 4'h0});
      was_on <= rv[0];
      wr_reg(`OFF_PL_CTRL, {lp, 2'(p), 5'h10});
      stby_on <= 1'b0;
      repeat (10) @(posedge clk);
      // the rail only falls once an earlier pass has raised it
      rd_chk(`OFF_EVT_STATUS, {2'h0, 1'(p > 0), ~on & lp, 4'h0});
      base = lo_cnt;
      @(posedge clk);
      stby_on <= 1'b1;
      repeat (60) @(posedge clk);
      chk(8'(lo_cnt - base), (on || !lp) ? 8'h00 : 8'(PC));
      chk({6'h0, sys_on, gate_n}, {6'h0, on, ~on});
      rd_chk(`OFF_EVT_STATUS, {2'h0, 1'b1, ~on & lp, 4'h0});
      rd_chk(`OFF_EVT_STATUS, {3'h0, ~on & lp, 4'h0});
    end
    close_out;
  end
endmodule
`default_nettype wire
